// >>> src/mar_regs.vh
// Purpose: Offsets, field positions and reset values of the attribute resolver
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Shared by the resolver and the bench
`ifndef MAR_REGS_VH
`define MAR_REGS_VH
// Register byte offsets
`define MAR_OFF_GCTL     12'h000
`define MAR_OFF_S2CE     12'h004
`define MAR_OFF_S1CTL    12'h008
`define MAR_OFF_S2CTL    12'h00c
`define MAR_OFF_CATTR    12'h010
`define MAR_OFF_STATUS   12'h014
// Override field positions, common to all configuration registers
`define MAR_F_SEC        0
`define MAR_F_WA         2
`define MAR_F_RA         4
`define MAR_F_MTEN       6
`define MAR_F_MK         8
`define MAR_F_SH         12
`define MAR_F_INST       14
`define MAR_F_PRIV       16
`define MAR_F_TR         18
`define MAR_F_TYPE       24
`define MAR_F_XLAT       24
`define MAR_F_SKIP       31
// Writable bits and reset values
`define MAR_WMASK        32'h830fff7f
`define MAR_TRMASK       32'h000c0000
`define MAR_RST_CFG      32'h00000000
`define MAR_RST_CATTR    32'h00000f00
// Stream entry type codes
`define MAR_T_XLAT       2'b00
`define MAR_T_BYP        2'b01
`define MAR_T_FAULT      2'b10
// Context format codes
`define MAR_C_S1BYP      2'b00
`define MAR_C_NEST       2'b01
`define MAR_C_S2ONLY     2'b10
// Attribute vector bit positions
`define MAR_A_NS         0
`define MAR_A_RA         1
`define MAR_A_WA         2
`define MAR_A_TR         3
`define MAR_A_MK         4
`define MAR_A_DEV        8
`define MAR_A_SH         10
`define MAR_A_INST       12
`define MAR_A_PRIV       13
`define MAR_AW           14
// Defaults for markings the upstream bus lacks
`define MAR_DEF_ATTR     14'h0cf7
`endif

// >>> src/mar_resolver.v
// Purpose: Resolves final memory attributes for each upstream transaction
// Assumes: Inputs synchronous to i_clk; descriptor inputs valid with i_in_valid
// Notes:   One register stage; address and attributes leave together
`include "mar_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module mar_resolver #(
    parameter       AW        = 32,
    parameter [6:0] UP_MARKS  = 7'h7f,
    parameter       DOWN_TR   = 1
) (
    input  wire          i_clk,
    input  wire          i_reset_n,
    input  wire          i_ce,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output wire          pready,
    output reg  [31:0]   prdata,
    output reg           pslverr,
    input  wire          i_in_valid,
    output wire          o_in_ready,
    input  wire [AW-1:0] i_in_addr,
    input  wire          i_in_write,
    input  wire [13:0]   i_in_attr,
    input  wire [13:0]   i_s1_desc_attr,
    input  wire [3:0]    i_s2_desc_mk,
    input  wire [1:0]    i_s2_desc_dev,
    input  wire [1:0]    i_s2_desc_sh,
    input  wire [1:0]    i_s2_desc_ra,
    input  wire [1:0]    i_s2_desc_wa,
    output reg           o_out_valid,
    input  wire          i_out_ready,
    output reg  [AW-1:0] o_out_addr,
    output reg           o_out_write,
    output reg  [13:0]   o_out_attr,
    output reg           o_out_fault
);

    reg  [31:0] global_control;
    reg  [31:0] stream_to_context_entry;
    reg  [31:0] s1_context_control;
    reg  [31:0] s2_context_control;
    reg  [31:0] context_attribute_register;
    reg  [13:0] last_attr;
    reg         last_fault;
    reg  [13:0] next_attr;
    reg         next_fault;
    reg  [13:0] in_attr;
    reg  [13:0] s1_attr;
    reg  [13:0] ent_attr;
    reg  [31:0] s2_cfg;
    reg  [3:0]  s2_mk;
    reg  [1:0]  s2_dev;
    reg  [1:0]  s2_sh;
    reg  [1:0]  s2_ra;
    reg  [1:0]  s2_wa;
    wire        wr_en;
    wire        take;
    wire [31:0] wdata;

    // Reserved memory kinds 0100, 1000, 1100 become device
    function [3:0] mar_dec_mk;
        input [3:0] m;
        begin
            mar_dec_mk = (m[1:0] == 2'b00) ? 4'h0 : m;
        end
    endfunction

    // Reserved shareability 00 becomes outer shareable
    function [1:0] mar_dec_sh;
        input [1:0] f;
        begin
            mar_dec_sh = (f == 2'b00) ? 2'b01 : f;
        end
    endfunction

    // Reserved hint 01 becomes the pass-through code
    function [1:0] mar_dec_hint;
        input [1:0] f;
        begin
            mar_dec_hint = (f == 2'b01) ? 2'b00 : f;
        end
    endfunction

    // Applies one configuration word's overrides to an attribute vector
    function [13:0] mar_ovr;
        input [13:0] a;
        input [31:0] c;
        input        full;
        input        fetch_priv;
        reg   [1:0]  f;
        reg   [3:0]  m;
        reg   [13:0] r;
        begin
            r = a;
            f = 2'b00;
            m = 4'h0;
            if (full) begin
                f = c[`MAR_F_SEC+:2];
                if (f == 2'b01)
                    f = 2'b11;
                if (f[1])
                    r[`MAR_A_NS] = f[0];
                f = mar_dec_hint(c[`MAR_F_RA+:2]);
                if (f[1])
                    r[`MAR_A_RA] = f[0];
                f = mar_dec_hint(c[`MAR_F_WA+:2]);
                if (f[1])
                    r[`MAR_A_WA] = f[0];
                f = mar_dec_hint(c[`MAR_F_TR+:2]);
                if (f[1])
                    r[`MAR_A_TR] = f[0];
                m = mar_dec_mk(c[`MAR_F_MK+:4]);
                // Without the enable only normal incoming memory is retyped
                if (c[`MAR_F_MTEN] || (a[`MAR_A_MK+:2] != 2'b00 &&
                                       a[`MAR_A_MK+2+:2] != 2'b00))
                    r[`MAR_A_MK+:4] = m;
                r[`MAR_A_SH+:2] = mar_dec_sh(c[`MAR_F_SH+:2]);
            end
            if (fetch_priv) begin
                f = c[`MAR_F_INST+:2];
                if (f == 2'b01)
                    f = 2'b11;
                if (f[1])
                    r[`MAR_A_INST] = f[0];
                f = c[`MAR_F_PRIV+:2];
                if (f == 2'b01)
                    f = 2'b10;
                if (f[1])
                    r[`MAR_A_PRIV] = f[0];
            end
            mar_ovr = r;
        end
    endfunction

    // Combines stage 1 with stage 2, stronger type and share win
    function [13:0] mar_comb;
        input [13:0] a;
        input [3:0]  mk;
        input [1:0]  dv;
        input [1:0]  sh;
        input [1:0]  ra;
        input [1:0]  wa;
        reg   [13:0] r;
        begin
            r = a;
            if (mk[1:0] < a[`MAR_A_MK+:2])
                r[`MAR_A_MK+:2] = mk[1:0];
            if (mk[3:2] < a[`MAR_A_MK+2+:2])
                r[`MAR_A_MK+2+:2] = mk[3:2];
            if (dv < a[`MAR_A_DEV+:2])
                r[`MAR_A_DEV+:2] = dv;
            if (sh < a[`MAR_A_SH+:2])
                r[`MAR_A_SH+:2] = sh;
            if (ra[1])
                r[`MAR_A_RA] = ra[0];
            if (wa[1])
                r[`MAR_A_WA] = wa[0];
            mar_comb = r;
        end
    endfunction

    // Bus slave answers in the access phase with no wait
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite & i_ce;
    // Transient field reads zero when the downstream bus lacks it
    assign wdata  = pwdata & `MAR_WMASK & ~(DOWN_TR ? 32'h0 : `MAR_TRMASK);

    // Configuration registers keep reserved codes as written
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            global_control             <= `MAR_RST_CFG;
            stream_to_context_entry    <= `MAR_RST_CFG;
            s1_context_control         <= `MAR_RST_CFG;
            s2_context_control         <= `MAR_RST_CFG;
            context_attribute_register <= `MAR_RST_CATTR;
        end else if (wr_en) begin
            case (paddr)
                `MAR_OFF_GCTL:  global_control <= wdata;
                `MAR_OFF_S2CE:  stream_to_context_entry <= wdata;
                `MAR_OFF_S1CTL: s1_context_control <= wdata;
                `MAR_OFF_S2CTL: s2_context_control <= wdata;
                `MAR_OFF_CATTR: context_attribute_register <= wdata;
                default: ;
            endcase
        end
    end

    // Read data captured in the setup phase, error on unmapped address
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (i_ce && psel && !penable) begin
            pslverr <= 1'b0;
            case (paddr)
                `MAR_OFF_GCTL:   prdata <= global_control;
                `MAR_OFF_S2CE:   prdata <= stream_to_context_entry;
                `MAR_OFF_S1CTL:  prdata <= s1_context_control;
                `MAR_OFF_S2CTL:  prdata <= s2_context_control;
                `MAR_OFF_CATTR:  prdata <= context_attribute_register;
                `MAR_OFF_STATUS: prdata <= {17'h0, last_fault, last_attr};
                default: begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // Upstream markings the bus lacks take their defaults
    always @* begin
        in_attr = i_in_attr;
        if (!UP_MARKS[0])
            in_attr[`MAR_A_NS] = 1'b1;
        if (!UP_MARKS[1])
            in_attr[`MAR_A_WA:`MAR_A_RA] = 2'b11;
        if (!UP_MARKS[2]) begin
            in_attr[`MAR_A_MK+:4]  = 4'hf;
            in_attr[`MAR_A_DEV+:2] = 2'b11;
        end
        if (!UP_MARKS[3])
            in_attr[`MAR_A_SH+:2] = 2'b11;
        if (!UP_MARKS[4])
            in_attr[`MAR_A_INST] = 1'b0;
        if (!UP_MARKS[5])
            in_attr[`MAR_A_PRIV] = 1'b0;
        if (!UP_MARKS[6])
            in_attr[`MAR_A_TR] = 1'b0;
        in_attr[`MAR_A_SH+:2] = mar_dec_sh(in_attr[`MAR_A_SH+:2]);
    end

    // Stage 1 result: entry transform, then control register or descriptor, except in stage-2-only format where only the entry transform applies
    always @* begin
        ent_attr = mar_ovr(in_attr, stream_to_context_entry, 1'b1, 1'b1);
        if (context_attribute_register[`MAR_F_TYPE+:2] == `MAR_C_S2ONLY)
            s1_attr = ent_attr;
        else if (s1_context_control[`MAR_F_XLAT]) begin
            s1_attr = i_s1_desc_attr;
            s1_attr[`MAR_A_INST] = ent_attr[`MAR_A_INST];
            s1_attr[`MAR_A_PRIV] = ent_attr[`MAR_A_PRIV];
        end else
            s1_attr = mar_ovr(ent_attr, s1_context_control, 1'b1, 1'b0);
    end

    // Stage 2 source chosen by context format and translation enable
    always @* begin
        s2_cfg = (context_attribute_register[`MAR_F_TYPE+:2] == `MAR_C_S1BYP) ?
                 context_attribute_register : s2_context_control;
        s2_mk  = mar_dec_mk(s2_cfg[`MAR_F_MK+:4]);
        s2_dev = 2'b11;
        s2_sh  = mar_dec_sh(s2_cfg[`MAR_F_SH+:2]);
        s2_ra  = mar_dec_hint(s2_cfg[`MAR_F_RA+:2]);
        s2_wa  = mar_dec_hint(s2_cfg[`MAR_F_WA+:2]);
        if (context_attribute_register[`MAR_F_TYPE+:2] != `MAR_C_S1BYP &&
            s2_context_control[`MAR_F_XLAT]) begin
            s2_mk  = i_s2_desc_mk;
            s2_dev = i_s2_desc_dev;
            s2_sh  = mar_dec_sh(i_s2_desc_sh);
            s2_ra  = mar_dec_hint(i_s2_desc_ra);
            s2_wa  = mar_dec_hint(i_s2_desc_wa);
        end
    end

    // Picks the configuration source and builds the final attributes
    always @* begin
        next_fault = 1'b0;
        if (global_control[`MAR_F_SKIP])
            next_attr = mar_ovr(in_attr, global_control, 1'b1, 1'b1);
        else begin
            case (stream_to_context_entry[`MAR_F_TYPE+:2])
                `MAR_T_BYP:
                    next_attr = mar_ovr(in_attr, stream_to_context_entry,
                                        1'b1, 1'b0);
                `MAR_T_XLAT:
                    next_attr = mar_comb(s1_attr, s2_mk, s2_dev, s2_sh,
                                         s2_ra, s2_wa);
                default: begin
                    next_attr  = in_attr;
                    next_fault = 1'b1;
                end
            endcase
        end
        if (i_in_write)
            next_attr[`MAR_A_INST] = 1'b0;
        if (next_attr[`MAR_A_MK+:2] < 2'b10 || next_attr[`MAR_A_MK+2+:2] < 2'b10)
            next_attr[`MAR_A_SH+:2] = 2'b01;
    end

    // Output stage holds one resolved transfer until taken
    assign o_in_ready = i_ce & (~o_out_valid | i_out_ready);
    assign take       = o_in_ready & i_in_valid;

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_out_valid <= 1'b0;
            o_out_addr  <= {AW{1'b0}};
            o_out_write <= 1'b0;
            o_out_attr  <= 14'h0;
            o_out_fault <= 1'b0;
            last_attr   <= 14'h0;
            last_fault  <= 1'b0;
        end else if (i_ce) begin
            if (take) begin
                o_out_valid <= 1'b1;
                o_out_addr  <= i_in_addr;
                o_out_write <= i_in_write;
                o_out_attr  <= next_attr;
                o_out_fault <= next_fault;
                last_attr   <= next_attr;
                last_fault  <= next_fault;
            end else if (i_out_ready)
                o_out_valid <= 1'b0;
        end
    end

endmodule // mar_resolver

`default_nettype wire

// >>> tb/mar_down_model.sv
// Purpose: Downstream interconnect model taking resolved transfers
// Assumes: One clock, synchronous active-low reset
// Notes:   Stalls follow a shift register, so runs repeat exactly
`timescale 1ns/10ps
`default_nettype none
module mar_down_model (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_slow,
    output var  logic o_ready
);
    logic [7:0] lfsr;
    // Ready every cycle when prompt, on about half the cycles when slow
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            lfsr    <= 8'h5a;
            o_ready <= 1'b0;
        end else begin
            lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            o_ready <= !i_slow | lfsr[0];
        end
    end
endmodule // mar_down_model
`default_nettype wire

// >>> tb/mar_resolver_asserts.sv
// Purpose: Concurrent checks on the attribute resolver ports
// Assumes: One clock, synchronous active-low reset, transient field stored
// Notes:   Bound to the resolver from the bench top file
`include "mar_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module mar_resolver_asserts #(
    parameter AW = 32
) (
    input wire logic          i_clk,
    input wire logic          i_reset_n,
    input wire logic          i_ce,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire logic          i_in_valid,
    input wire logic          o_in_ready,
    input wire logic [AW-1:0] i_in_addr,
    input wire logic          i_in_write,
    input wire logic          o_out_valid,
    input wire logic          i_out_ready,
    input wire logic [AW-1:0] o_out_addr,
    input wire logic          o_out_write,
    input wire logic [13:0]   o_out_attr,
    input wire logic          o_out_fault
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic [31:0] shadow_gctl;
    // Mirror of the writable global control bits
    always @(posedge i_clk) begin
        if (!i_reset_n)
            shadow_gctl <= `MAR_RST_CFG;
        else if (i_ce && psel && penable && pwrite && paddr == `MAR_OFF_GCTL)
            shadow_gctl <= pwdata & `MAR_WMASK;
    end
    hold_stall_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid
        && $stable(o_out_addr) && $stable(o_out_attr) && $stable(o_out_write))
        else $error("output changed while stalled");
    take_answer_a: assert property (i_in_valid && o_in_ready |=> o_out_valid
        && o_out_addr == $past(i_in_addr) && o_out_write == $past(i_in_write))
        else $error("taken request not issued next cycle");
    out_drop_a: assert property (o_out_valid && i_out_ready && i_ce
        && !(i_in_valid && o_in_ready) |=> !o_out_valid)
        else $error("output valid after handover");
    ready_block_a: assert property (!i_ce || (o_out_valid && !i_out_ready) |-> !o_in_ready)
        else $error("request accepted while blocked");
    write_data_a: assert property (o_out_valid && o_out_write && !o_out_fault
        |-> !o_out_attr[`MAR_A_INST])
        else $error("write issued as instruction");
    dev_outer_a: assert property (o_out_valid && !o_out_fault
        && (o_out_attr[5:4] < 2'b10 || o_out_attr[7:6] < 2'b10) |-> o_out_attr[11:10] == 2'b01)
        else $error("device or uncached not outer shareable");
    gctl_readback_a: assert property (psel && penable && !pwrite
        && paddr == `MAR_OFF_GCTL |-> prdata == shadow_gctl && !pslverr)
        else $error("global control read back wrong");
    unmapped_err_a: assert property (psel && penable && paddr >= 12'h018
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    cover property (o_out_valid && !i_out_ready ##1 o_out_valid);
    cover property (o_out_valid && o_out_fault);
    cover property (o_out_valid && o_out_write && i_out_ready);
endmodule // mar_resolver_asserts
`default_nettype wire

// >>> tb/tb_mar_resolver.sv
// Purpose: Self-checking bench for the attribute resolver
// Assumes: Zero-wait register bus, downstream model stalls at random
// Notes:   Seeded random override checks among directed corner cases
`include "mar_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_mar_resolver;
    localparam AW = 32;
    logic          i_clk = 1'b0, i_reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic          i_in_valid = 1'b0, i_in_write = 1'b0, slow = 1'b0, ce = 1'b1, er, ft, w;
    logic [11:0]   paddr = 12'h000, s2d = 12'h000;
    logic [31:0]   pwdata = 32'h0, rd, v;
    logic [AW-1:0] i_in_addr = '0;
    logic [13:0]   i_in_attr = 14'h0, i_s1_desc_attr = 14'h0, at, a;
    wire  [31:0]   prdata;
    wire  [AW-1:0] o_out_addr;
    wire  [13:0]   o_out_attr;
    wire           pready, pslverr, o_in_ready, o_out_valid, i_out_ready, o_out_write, o_out_fault;
    int            num_errors = 0, check_count = 0, i;

    mar_resolver #(.AW(AW)) dut_u (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
        .i_in_addr(i_in_addr), .i_in_write(i_in_write), .i_in_attr(i_in_attr),
        .i_s1_desc_attr(i_s1_desc_attr), .i_s2_desc_mk(s2d[3:0]), .i_s2_desc_dev(s2d[5:4]),
        .i_s2_desc_sh(s2d[7:6]), .i_s2_desc_ra(s2d[9:8]), .i_s2_desc_wa(s2d[11:10]),
        .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_addr(o_out_addr),
        .o_out_write(o_out_write), .o_out_attr(o_out_attr), .o_out_fault(o_out_fault));
    mar_down_model dn_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow(slow), .o_ready(i_out_ready));

    always #25 i_clk = ~i_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic stop();
        num_errors++;
        close_out();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Override code: 00 keeps the incoming bit, 01 takes its substitute, 1x sets bit 0
    function automatic logic dec(input logic [1:0] c, input logic b, input logic r);
        return (c == 2'b00) ? b : (c == 2'b01) ? r : c[0];
    endfunction
    // One register bus transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (!pready && ++n < 20);
        if (n >= 20) stop();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One upstream request, then wait for its resolved transfer downstream
    task automatic xfer(input logic wr, input logic [13:0] aa);
        logic [AW-1:0] ad;
        int n = 0;
        @(posedge i_clk);
        i_in_valid <= 1'b1;
        i_in_write <= wr;
        i_in_attr <= aa;
        i_in_addr <= $urandom;
        s2d <= 12'($urandom);
        i_s1_desc_attr <= 14'($urandom);
        slow <= 1'($urandom);
        do @(posedge i_clk); while (!o_in_ready && ++n < 50);
        ad = i_in_addr;
        i_in_valid <= 1'b0;
        do @(posedge i_clk); while (!(o_out_valid && i_out_ready) && ++n < 100);
        if (n >= 100) stop();
        chk(o_out_addr, ad);
        chk(32'(o_out_write), 32'(wr));
        at = o_out_attr;
        ft = o_out_fault;
    endtask

    initial begin
        i = $urandom(26429);
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        apb(1'b0, `MAR_OFF_CATTR, 32'h0, rd, er);
        chk(rd, `MAR_RST_CATTR);
        apb(1'b0, `MAR_OFF_S2CE, 32'h0, rd, er);
        chk(rd, `MAR_RST_CFG);
        apb(1'b1, 12'h018, 32'hffff_ffff, rd, er);
        chk(32'(er), 32'h1);
        $display("test reset_values done");
        // Global skip with every memory kind that decodes to device
        for (i = 0; i < 4; i++) begin
            v = 32'h8000_0040 | (i << 10) | ((i == 0) ? 32'h3 : 32'h1);
            apb(1'b1, `MAR_OFF_GCTL, v, rd, er);
            apb(1'b0, `MAR_OFF_GCTL, 32'h0, rd, er);
            chk(rd, v & `MAR_WMASK);
            xfer(1'b0, 14'h0cf6);
            chk(32'(at[0]), 32'h1);
            chk(32'(at[7:4]), 32'h0);
            chk(32'(at[11:10]), 32'h1);
        end
        $display("test global_skip done");
        // Stream entry bypass, then both fault types
        apb(1'b1, `MAR_OFF_GCTL, 32'h0, rd, er);
        apb(1'b1, `MAR_OFF_S2CE, 32'h0100_0003, rd, er);
        xfer(1'b1, 14'h0cf6);
        chk(32'(at[0]), 32'h1);
        chk(32'(ft), 32'h0);
        for (i = 2; i < 4; i++) begin
            apb(1'b1, `MAR_OFF_S2CE, 32'(i) << 24, rd, er);
            xfer(1'b0, 14'h0cf6);
            chk(32'(ft), 32'h1);
        end
        $display("test bypass_fault done");
        // Random translation-context overrides, reads and writes mixed
        for (i = 0; i < 40; i++) begin
            v = $urandom & 32'h0003_c003;
            w = 1'($urandom);
            a = 14'($urandom) & 14'h3ffe;
            if (a[5:4] == 2'b00 || a[7:6] == 2'b00) a[7:4] = 4'h0;
            apb(1'b1, `MAR_OFF_S2CE, v, rd, er);
            xfer(w, a);
            chk(32'(at[0]), 32'(dec(v[1:0], a[0], 1'b1)));
            chk(32'(at[12]), 32'(w ? 1'b0 : dec(v[15:14], a[12], 1'b1)));
            chk(32'(at[13]), 32'(dec(v[17:16], a[13], 1'b0)));
        end
        $display("test random_overrides done");
        // Writes made while the clock enable is low are lost, requests refused
        ce <= 1'b0;
        apb(1'b1, `MAR_OFF_GCTL, 32'h0000_0003, rd, er);
        chk(32'(o_in_ready), 32'h0);
        ce <= 1'b1;
        apb(1'b0, `MAR_OFF_GCTL, 32'h0, rd, er);
        chk(rd, 32'h0);
        $display("test clock_enable done");
        close_out();
    end
endmodule // tb_mar_resolver

bind mar_resolver mar_resolver_asserts #(.AW(AW)) chk_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_addr(i_in_addr),
    .i_in_write(i_in_write), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_addr(o_out_addr), .o_out_write(o_out_write), .o_out_attr(o_out_attr),
    .o_out_fault(o_out_fault));
`default_nettype wire
